/* include/scm_defines.svh */
// Constants for the system clock block: register map, field
// positions, reset values and timing counts.
// Assumes a 10 MHz system clock and a 32-bit APB register bus.
`ifndef SCM_DEFINES_SVH
`define SCM_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCM_AW          8
`define SCM_OFF_OSC     8'h00
`define SCM_OFF_TRIM    8'h04
`define SCM_OFF_REF     8'h08
`define SCM_OFF_MULT    8'h0C
`define SCM_OFF_SRC     8'h10
`define SCM_OFF_STAT    8'h14

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SCM_DIV_MSB     2
`define SCM_SUSP_BIT    5
`define SCM_ORUN_BIT    6
`define SCM_DIV_RST     3'h7
`define SCM_CT_MSB      7
`define SCM_FT_LSB      8
`define SCM_FT_MSB      15
`define SCM_CT_RST      8'h40
`define SCM_FT_RST      8'h20
`define SCM_ZTC_BIT     0
`define SCM_MSEL_MSB    1
`define SCM_MDIV_LSB    2
`define SCM_MDIV_MSB    4
`define SCM_MRDY_BIT    5
`define SCM_MINIT_BIT   6
`define SCM_MEN_BIT     7
`define SCM_SRC_BIT     0

// ----------------------------------------------------------------
// Multiplier arithmetic and timing
// ----------------------------------------------------------------
`define SCM_ACC_ADD     6'h08
`define SCM_ACC_CAP     6'h30
`define SCM_N_BASE      3'h2
`define SCM_N_MAX       3'h7
`define SCM_MDIV_TOP    3'h5
`define SCM_CLK_MHZ     10
`define SCM_OSC_MHZ     24
`define SCM_LOCK_NS     1600

`endif

/* include/scm_pkg.sv */
// Types shared by the system clock block.
// Assumes scm_defines.svh supplies the numeric constants.
package scm_pkg;

   // Multiplier bring-up states
   typedef enum logic [1:0] {
      SCM_M_OFF  = 2'b00,
      SCM_M_ON   = 2'b01,
      SCM_M_LOCK = 2'b10,
      SCM_M_RDY  = 2'b11
   } scm_mstate_t;

   // Multiplier input sources
   typedef enum logic [1:0] {
      SCM_IN_EXT  = 2'b00,
      SCM_IN_INT2 = 2'b01,
      SCM_IN_EXT2 = 2'b10
   } scm_msel_t;

endpackage : scm_pkg

/* verilog/scm_pow2_div.sv */
// Power-of-two divider for an enable stream.
// Assumes tick_i is a one-cycle enable on clk_sys_i.
`timescale 1ns/10ps
`include "scm_defines.svh"
module scm_pow2_div
   import scm_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       nrst_i,
   input  wire logic       tick_i,
   input  wire logic [2:0] sel_i,
   output logic            tick_o
);

   logic [6:0] cnt_ff;

   // Mask of low counter bits for a divide by two to the sel
   function automatic logic [6:0] div_mask(input logic [2:0] s);
      div_mask = 7'((8'h01 << s) - 8'h01);
   endfunction : div_mask

   // Pass one tick in every 2**sel
   assign tick_o = tick_i & ((cnt_ff & div_mask(sel_i)) == div_mask(sel_i));

   // Free counter of source ticks
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_ff <= 7'h00;
      end else if (tick_i) begin
         cnt_ff <= cnt_ff + 7'h01;
      end
   end

endmodule : scm_pow2_div

/* verilog/scm_mult_burst.sv */
// Clock multiplier core: four output ticks per input edge,
// scaled by 2/n. Assumes edge_i is a one-cycle enable.
`timescale 1ns/10ps
`include "scm_defines.svh"
module scm_mult_burst
   import scm_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       nrst_i,
   input  wire logic       run_i,
   input  wire logic       edge_i,
   input  wire logic [2:0] scale_i,
   output logic            pulse_o
);

   logic [5:0] acc_ff;
   logic [5:0] nxt_acc;
   logic [2:0] den;
   logic       add;

   // Scale code 0..5 gives 2/2..2/7; codes above clamp to 2/7
   // Clamping keeps stray codes from pushing the output out of range
   assign den = (scale_i > `SCM_MDIV_TOP) ? `SCM_N_MAX : scale_i + `SCM_N_BASE; // RULE18
   // Eight credits per edge, n spent per pulse: 8/n pulses per edge
   assign add     = run_i & edge_i & (acc_ff < `SCM_ACC_CAP);
   assign pulse_o = run_i & (acc_ff >= {3'h0, den});        // RULE11
   // Pulses leave back to back, then idle to the next edge
   assign nxt_acc = !run_i ? 6'h00 :
                    acc_ff + (add ? `SCM_ACC_ADD : 6'h00)
                           - (pulse_o ? {3'h0, den} : 6'h00); // RULE19

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_ff <= 6'h00;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

endmodule : scm_mult_burst

/* verilog/scm_sysclk.sv */
// System clock control: internal oscillator with divider,
// oscillator suspend with wake-up, and the clock multiplier.
// Assumes an APB master on clk_sys_i; wake and oscillator pins
// arrive asynchronously and are synchronised here.
`timescale 1ns/10ps
`include "scm_defines.svh"

// How it works
// [RULE1] Reset makes the divided internal oscillator the system clock.
// [RULE2] Trim registers reset to factory values for a 24 MHz oscillator.
// [RULE3] Internal oscillator divided by 1 to 128 under a select field.
// [RULE4] The divide select resets to divide by 128.
// [RULE5] Writing one to the suspend bit halts the internal oscillator.
// [RULE6] Suspended on internal oscillator: core and peripheral clocks stop.
// [RULE7] Port 0..3 match, or enabled comparator low, ends suspend.
// [RULE8] Wake restarts oscillator and clocks, interrupt or not.
// [RULE9] Core resumes after the write that set suspend.
// [RULE10] Software sets the bias enable bit before suspending.
// [RULE11] Multiplier gives four times input, scaled 1 to 2/7.
// [RULE12] Multiplier input: external, internal halved or external halved.
// [RULE13] Software resets the multiplier by writing zero to its control.
// [RULE14] Software picks input then scale before enabling.
// [RULE15] Software enables, then waits over 5 us before initialising.
// [RULE16] Software sets initialise, then polls the ready flag.
// [RULE17] External source must be stable before initialising.
// [RULE18] Multiplier is meant for a 25 to 50 MHz core clock.
// [RULE19] Slow input gives four fast pulses per edge, then a hold.
// [RULE20] Ready low unless locked; multiplier not used until ready.
module scm_sysclk
   import scm_pkg::*;
(
   input  wire logic                clk_sys_i,
   input  wire logic                nrst_i,
   // APB slave
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [`SCM_AW-1:0]  paddr_i,
   input  wire logic [31:0]         pwdata_i,
   output logic [31:0]              prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   // Asynchronous pins
   input  wire logic                ext_osc_i,
   input  wire logic [3:0]          port_match_i,
   input  wire logic                cmp0_en_i,
   input  wire logic                cmp0_out_i,
   // Clock enables and status
   output logic                     sysclk_en_o,
   output logic                     core_clk_en_o,
   output logic                     mult_clk_en_o,
   output logic                     osc_run_o,
   output logic                     suspended_o,
   output logic                     mult_ready_flag_o,
   output logic                     zero_tempco_bias_enable_o,
   output logic [7:0]               osc_coarse_trim_o,
   output logic [7:0]               osc_fine_trim_o
);

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   // Lock wait after initialise, rounded up to whole cycles
   localparam int LOCK_CYC_I = (`SCM_LOCK_NS * `SCM_CLK_MHZ + 999) / 1000;
   localparam logic [7:0] LOCK_LAST = 8'(LOCK_CYC_I - 1);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [6:0]  pin_s1_ff;
   logic [6:0]  pin_s2_ff;
   logic [6:0]  pin_vec;
   logic        ext_d_ff;
   logic        ext_half_ff;
   logic        int_half_ff;

   logic        pready_ff;
   logic        pslverr_ff;
   logic [31:0] prdata_ff;

   logic [2:0]  div_sel_ff;
   logic        suspend_ff;
   logic        osc_run_ff;
   logic [7:0]  coarse_ff;
   logic [7:0]  fine_ff;
   logic        ztc_ff;
   logic        use_mult_ff;

   logic        men_ff;
   logic        minit_ff;
   logic [1:0]  msel_ff;
   logic [2:0]  mdiv_ff;
   scm_mstate_t mst_ff;
   scm_mstate_t nxt_mst;
   logic [7:0]  lock_cnt_ff;
   logic [7:0]  nxt_lock_cnt;

   logic        sysclk_en_ff;
   logic        core_en_ff;
   logic        mult_en_ff;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Every pin passes two flops before any logic reads it
   assign pin_vec = {cmp0_out_i, cmp0_en_i, port_match_i, ext_osc_i};

   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_sync
         always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
               pin_s1_ff[gi] <= 1'b0;
               pin_s2_ff[gi] <= 1'b0;
            end else begin
               pin_s1_ff[gi] <= pin_vec[gi];
               pin_s2_ff[gi] <= pin_s1_ff[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // Exact byte address match against a register offset
   function automatic logic is_reg(input logic [`SCM_AW-1:0] a,
                                   input logic [`SCM_AW-1:0] off);
      is_reg = (a == off);
   endfunction : is_reg

   wire setup    = psel_i & ~penable_i;
   wire wr_acc   = psel_i & penable_i & pready_ff & pwrite_i;
   wire hit_osc  = is_reg(paddr_i, `SCM_OFF_OSC);
   wire hit_trim = is_reg(paddr_i, `SCM_OFF_TRIM);
   wire hit_ref  = is_reg(paddr_i, `SCM_OFF_REF);
   wire hit_mult = is_reg(paddr_i, `SCM_OFF_MULT);
   wire hit_src  = is_reg(paddr_i, `SCM_OFF_SRC);
   wire hit_stat = is_reg(paddr_i, `SCM_OFF_STAT);
   wire mapped   = hit_osc | hit_trim | hit_ref | hit_mult | hit_src | hit_stat;

   // Per-register write strobes
   wire wr_osc   = wr_acc & hit_osc;
   wire wr_trim  = wr_acc & hit_trim;
   wire wr_ref   = wr_acc & hit_ref;
   wire wr_mult  = wr_acc & hit_mult;
   wire wr_src   = wr_acc & hit_src;

   // ----------------------------------------------------------------
   // Clock paths
   // ----------------------------------------------------------------
   // Multiplier stays out of the clock path until ready
   wire mult_rdy = (mst_ff == SCM_M_RDY);                      // RULE20
   wire eff_mult = use_mult_ff & mult_rdy;                      // RULE20
   wire int_tick = osc_run_ff;
   wire int_div_tick;
   wire mult_pulse;

   // Wake: any port match, or comparator enabled with output low
   wire wake = (|pin_s2_ff[4:1]) | (pin_s2_ff[5] & ~pin_s2_ff[6]); // RULE7

   // Input edges for the three multiplier sources
   wire ext_rise  = pin_s2_ff[0] & ~ext_d_ff;
   wire ext2_edge = ext_rise & ext_half_ff;
   wire int2_edge = int_tick & int_half_ff;
   wire mult_edge = (msel_ff == SCM_IN_EXT)  ? ext_rise  :
                    (msel_ff == SCM_IN_INT2) ? int2_edge :
                    ext2_edge;                                  // RULE12
   wire mult_run  = (mst_ff == SCM_M_LOCK) | mult_rdy;

   // Source select: divided internal oscillator unless multiplier selected and ready
   wire sys_tick  = eff_mult ? mult_pulse : int_div_tick;      // RULE1
   // Suspend on the internal oscillator stops core and peripherals
   wire on_int    = ~eff_mult;
   wire core_tick = sys_tick & ~(suspend_ff & on_int);         // RULE6

   // Internal oscillator divider, one to 128
   scm_pow2_div u_int_div (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .tick_i    (int_tick),
      .sel_i     (div_sel_ff),
      .tick_o    (int_div_tick)
   );                                                           // RULE3

   // Multiplier pulse generator
   scm_mult_burst u_mult (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .run_i     (mult_run),
      .edge_i    (mult_edge),
      .scale_i   (mdiv_ff),
      .pulse_o   (mult_pulse)
   );

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   wire [31:0] rd_osc  = {25'h0, osc_run_ff, suspend_ff, 2'h0, div_sel_ff};
   wire [31:0] rd_trim = {16'h0, fine_ff, coarse_ff};
   wire [31:0] rd_ref  = {31'h0, ztc_ff};
   wire [31:0] rd_mult = {24'h0, men_ff, minit_ff, mult_rdy, mdiv_ff, msel_ff};
   wire [31:0] rd_src  = {31'h0, use_mult_ff};
   wire [31:0] rd_stat = {28'h0, mst_ff, suspend_ff, eff_mult};
   wire [31:0] rd_data = hit_osc  ? rd_osc  :
                         hit_trim ? rd_trim :
                         hit_ref  ? rd_ref  :
                         hit_mult ? rd_mult :
                         hit_src  ? rd_src  :
                         hit_stat ? rd_stat : 32'h0000_0000;

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // One access cycle per transfer; data captured at setup
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= setup & ~mapped;
         if (setup) begin
            prdata_ff <= rd_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // Oscillator control
   // ----------------------------------------------------------------
   // Divide select and trims; trims hold factory values after reset
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_sel_ff <= `SCM_DIV_RST;                            // RULE4
         coarse_ff  <= `SCM_CT_RST;                             // RULE2
         fine_ff    <= `SCM_FT_RST;                             // RULE2
      end else begin
         if (wr_osc) begin
            div_sel_ff <= pwdata_i[`SCM_DIV_MSB:0];             // RULE3
         end
         if (wr_trim) begin
            coarse_ff <= pwdata_i[`SCM_CT_MSB:0];
            fine_ff   <= pwdata_i[`SCM_FT_MSB:`SCM_FT_LSB];
         end
      end
   end

   // Suspend: a write of one wins over a wake in the same cycle,
   // so the request is never lost; a lasting wake ends it next cycle
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         suspend_ff <= 1'b0;
      end else if (wr_osc & pwdata_i[`SCM_SUSP_BIT]) begin
         suspend_ff <= 1'b1;                                    // RULE5
      end else if (wake) begin
         suspend_ff <= 1'b0;                                    // RULE8
      end
   end

   // Oscillator runs whenever not suspended; the core is only gated,
   // never reset, so it picks up at the next instruction
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         osc_run_ff <= 1'b1;
      end else begin
         osc_run_ff <= ~suspend_ff;                             // RULE9
      end
   end

   // Bias enable and system clock source select
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ztc_ff      <= 1'b0;
         use_mult_ff <= 1'b0;                                   // RULE1
      end else begin
         if (wr_ref) begin
            ztc_ff <= pwdata_i[`SCM_ZTC_BIT];
         end
         if (wr_src) begin
            use_mult_ff <= pwdata_i[`SCM_SRC_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Multiplier control
   // ----------------------------------------------------------------
   // Control fields; a write of zero clears them all and so resets
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         men_ff   <= 1'b0;
         minit_ff <= 1'b0;
         msel_ff  <= 2'h0;
         mdiv_ff  <= 3'h0;
      end else if (wr_mult) begin
         men_ff   <= pwdata_i[`SCM_MEN_BIT];
         minit_ff <= pwdata_i[`SCM_MINIT_BIT];
         msel_ff  <= pwdata_i[`SCM_MSEL_MSB:0];
         mdiv_ff  <= pwdata_i[`SCM_MDIV_MSB:`SCM_MDIV_LSB];
      end
   end

   // Bring-up sequence: off, enabled, locking, ready
   always_comb begin
      nxt_mst      = mst_ff;
      nxt_lock_cnt = lock_cnt_ff;
      case (mst_ff)
         SCM_M_OFF: begin
            if (men_ff) begin
               nxt_mst = SCM_M_ON;
            end
         end
         SCM_M_ON: begin
            if (!men_ff) begin
               nxt_mst = SCM_M_OFF;
            end else if (minit_ff) begin
               nxt_mst      = SCM_M_LOCK;
               nxt_lock_cnt = 8'h00;
            end
         end
         SCM_M_LOCK: begin
            if (!men_ff) begin
               nxt_mst = SCM_M_OFF;
            end else if (!minit_ff) begin
               nxt_mst = SCM_M_ON;
            end else if (lock_cnt_ff == LOCK_LAST) begin
               nxt_mst = SCM_M_RDY;                             // RULE16
            end else begin
               nxt_lock_cnt = lock_cnt_ff + 8'h01;
            end
         end
         SCM_M_RDY: begin
            if (!men_ff) begin
               nxt_mst = SCM_M_OFF;                             // RULE20
            end else if (!minit_ff) begin
               nxt_mst = SCM_M_ON;                              // RULE20
            end
         end
         default: begin
            nxt_mst = SCM_M_OFF;
         end
      endcase
   end

   // State, lock counter and source edge history
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mst_ff      <= SCM_M_OFF;
         lock_cnt_ff <= 8'h00;
         ext_d_ff    <= 1'b0;
         ext_half_ff <= 1'b0;
         int_half_ff <= 1'b0;
      end else begin
         mst_ff      <= nxt_mst;
         lock_cnt_ff <= nxt_lock_cnt;
         ext_d_ff    <= pin_s2_ff[0];
         if (ext_rise) begin
            ext_half_ff <= ~ext_half_ff;
         end
         if (int_tick) begin
            int_half_ff <= ~int_half_ff;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   // Enables are registered, adding one cycle of latency to each
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sysclk_en_ff <= 1'b0;
         core_en_ff   <= 1'b0;
         mult_en_ff   <= 1'b0;
      end else begin
         sysclk_en_ff <= sys_tick;
         core_en_ff   <= core_tick;                             // RULE6
         mult_en_ff   <= mult_pulse;                            // RULE11
      end
   end

   assign prdata_o                  = prdata_ff;
   assign pready_o                  = pready_ff;
   assign pslverr_o                 = pslverr_ff;
   assign sysclk_en_o               = sysclk_en_ff;
   assign core_clk_en_o             = core_en_ff;
   assign mult_clk_en_o             = mult_en_ff;
   assign osc_run_o                 = osc_run_ff;
   assign suspended_o               = suspend_ff;
   assign mult_ready_flag_o         = mst_ff == SCM_M_RDY;
   assign zero_tempco_bias_enable_o = ztc_ff;
   assign osc_coarse_trim_o         = coarse_ff;
   assign osc_fine_trim_o           = fine_ff;

endmodule : scm_sysclk

/* bench/scm_sysclk_assertions.sv */
// Checker for scm_sysclk: bus answer, suspend, wake, ready.
// Assumes it is bound to scm_sysclk and sees only its ports.
`timescale 1ns/10ps
`include "scm_defines.svh"
module scm_sysclk_assertions
   import scm_pkg::*;
(
   input wire logic               clk_sys_i,
   input wire logic               nrst_i,
   input wire logic               psel_i,
   input wire logic               penable_i,
   input wire logic               pwrite_i,
   input wire logic [`SCM_AW-1:0] paddr_i,
   input wire logic [31:0]        pwdata_i,
   input wire logic [31:0]        prdata_o,
   input wire logic               pready_o,
   input wire logic               pslverr_o,
   input wire logic               ext_osc_i,
   input wire logic [3:0]         port_match_i,
   input wire logic               cmp0_en_i,
   input wire logic               cmp0_out_i,
   input wire logic               sysclk_en_o,
   input wire logic               core_clk_en_o,
   input wire logic               mult_clk_en_o,
   input wire logic               osc_run_o,
   input wire logic               suspended_o,
   input wire logic               mult_ready_flag_o,
   input wire logic               zero_tempco_bias_enable_o,
   input wire logic [7:0]         osc_coarse_trim_o,
   input wire logic [7:0]         osc_fine_trim_o
);
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   // Completed write to the multiplier control
   wire mult_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == `SCM_OFF_MULT;
   wire wake = (|port_match_i) || (cmp0_en_i && !cmp0_out_i);

   AST_APB_ANSWER: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   AST_READY_PULSE: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   AST_ERR_READY: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   AST_SUSP_HALT: assert property ($rose(suspended_o) |=> !osc_run_o)
      else $error("oscillator still running");
   AST_GATE: assert property (suspended_o && $past(suspended_o) && !mult_ready_flag_o
      |-> !core_clk_en_o) else $error("core clock not gated");
   AST_WAKE: assert property (suspended_o && wake |-> ##[1:6] !suspended_o)
      else $error("no wake");
   AST_RESTART: assert property ($fell(suspended_o) |=> osc_run_o)
      else $error("oscillator not restarted");
   AST_READY_DROP: assert property (mult_wr && pwdata_i[7:6] != 2'b11 |-> ##2 !mult_ready_flag_o)
      else $error("ready not dropped");
   AST_LOCK_WAIT: assert property (mult_wr && pwdata_i[7:6] == 2'b11 && !mult_ready_flag_o
      |=> !mult_ready_flag_o [*8]) else $error("ready too early");
   // Main scenarios
   cover property ($rose(mult_ready_flag_o));
   cover property ($fell(suspended_o));
   cover property (pslverr_o);
endmodule : scm_sysclk_assertions

bind scm_sysclk scm_sysclk_assertions scm_sysclk_assertions_i (.*);

/* bench/sysclk_osc_divider_multiplier_tb_top.sv */
// Directed testbench for scm_sysclk over APB.
// Assumes the checker binds itself from its own file.
`timescale 1ns/10ps
`include "scm_defines.svh"
module sysclk_osc_divider_multiplier_tb_top;
   logic clk_sys_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [`SCM_AW-1:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic ext_osc_i, cmp0_en_i, cmp0_out_i, sysclk_en_o, core_clk_en_o, mult_clk_en_o;
   logic osc_run_o, suspended_o, mult_ready_flag_o, zero_tempco_bias_enable_o, err;
   logic [3:0] port_match_i;
   logic [7:0] osc_coarse_trim_o, osc_fine_trim_o;
   int error_cnt, check_count, cyc, n;
   bit ext_run;

   scm_sysclk scm_sysclk_i (.*);

   // ---------------------------------------------
   // Clock, timeout, slow external oscillator
   // ---------------------------------------------
   initial begin
      clk_sys_i = 0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   // Edge every 16 cycles: slow enough for whole bursts
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (ext_run && cyc % 8 == 0) ext_osc_i <= ~ext_osc_i;
      if (cyc == 6000) begin
         error_cnt++;
         complete_run();
      end
   end

   task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask : check

   // One APB transfer; waits for ready, bounded by the timeout
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1;
      do @(posedge clk_sys_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask : apb

   task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(0, a, 0);
      check(nm, exp, rd);
   endtask : rdc

   // Count pulses: 0 system, 1 multiplier, 2 core
   task pulses(input int which, input int cycles, output int c);
      c = 0;
      repeat (cycles) begin
         @(posedge clk_sys_i);
         #1;
         c += which == 0 ? sysclk_en_o === 1'b1 : which == 1 ? mult_clk_en_o === 1'b1
            : core_clk_en_o === 1'b1;
      end
   endtask : pulses

   task complete_run();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   // ---------------------------------------------
   // Sequence
   // ---------------------------------------------
   initial begin
      {nrst_i, psel_i, penable_i, pwrite_i, ext_osc_i, cmp0_en_i} = 0;
      {paddr_i, pwdata_i, port_match_i, cyc, error_cnt, check_count} = 0;
      cmp0_out_i = 1;
      repeat (10) @(posedge clk_sys_i);
      nrst_i <= 1;
      rdc("osc", `SCM_OFF_OSC, 32'h0000_0047);
      rdc("trim", `SCM_OFF_TRIM, 32'h0000_2040);
      check("ctrim", 32'h0000_0040, osc_coarse_trim_o);
      check("ftrim", 32'h0000_0020, osc_fine_trim_o);
      pulses(0, 256, n);
      check("div128", 2, n);
      for (int k = 0; k < 4; k++) begin
         apb(1, `SCM_OFF_OSC, k);
         pulses(0, 16, n);
         pulses(0, 64, n);
         check("div", 64 >> k, n);
      end
      apb(1, `SCM_OFF_REF, 1);
      // The write lands at the edge the task returns on; look one edge later
      @(posedge clk_sys_i);
      check("ztc", 1, zero_tempco_bias_enable_o);
      // Every wake source once; divider left at 8 so gating shows
      for (int k = 0; k < 5; k++) begin
         apb(1, `SCM_OFF_OSC, 32'h0000_0023);
         repeat (3) @(posedge clk_sys_i);
         check("halt", 0, osc_run_o);
         pulses(2, 40, n);
         check("gated", 0, n);
         if (k < 4) port_match_i <= 4'h1 << k;
         else cmp0_out_i <= 0;
         cmp0_en_i <= 1;
         repeat (8) @(posedge clk_sys_i);
         check("wake", 0, suspended_o);
         check("restart", 1, osc_run_o);
         port_match_i <= 0;
         cmp0_en_i <= 0;
         cmp0_out_i <= 1;
         rdc("resume", `SCM_OFF_OSC, 32'h0000_0043);
      end
      ext_run <= 1;
      // Pass 0: external input, scale 1; pass 2: external halved, scale 1/2
      for (int k = 0; k < 4; k += 2) begin
         apb(1, `SCM_OFF_MULT, 0);
         apb(1, `SCM_OFF_MULT, k << 2 | k);
         apb(1, `SCM_OFF_MULT, 32'h80 | k << 2 | k);
         repeat (60) @(posedge clk_sys_i);
         rdc("notrdy", `SCM_OFF_MULT, 32'h80 | k << 2 | k);
         apb(1, `SCM_OFF_MULT, 32'hC0 | k << 2 | k);
         do apb(0, `SCM_OFF_MULT, 0); while (rd[5] !== 1'b1);
         check("rdy", 32'hE0 | k << 2 | k, rd);
         check("rdyo", 1, mult_ready_flag_o);
         @(posedge ext_osc_i);
         pulses(1, 160, n);
         check("mult", k == 0 ? 40 : 10, n);
      end
      apb(1, `SCM_OFF_SRC, 1);
      @(posedge ext_osc_i);
      pulses(0, 160, n);
      check("src", 10, n);
      apb(1, `SCM_OFF_MULT, 0);
      rdc("mreset", `SCM_OFF_MULT, 0);
      pulses(0, 16, n);
      pulses(0, 64, n);
      check("back", 8, n);
      apb(0, 8'h40, 0);
      check("slverr", 1, err);
      check("rdz", 0, rd);
      complete_run();
   end
endmodule : sysclk_osc_divider_multiplier_tb_top
